// *** pkg/nfcu_pkg.sv ***
// Constants, types and encodings of the number-format conversion unit
// Operation
// - Hex-to-ASCII turns each hex digit into one ASCII byte, doubling table words.
// - Digits 0-9 become 30h-39h; digits A-F become 41h-46h.
// - Table operands beyond accumulator or address reach raise the operand range flag.
// - Segment-encode turns four accumulator hex digits into seven-segment patterns.
// - Gray-to-BCD converts 16-bit Gray input, upper accumulator bits forced to zero.
// - Conversion is direct for 512 and 1024 count encoders.
// - Gray and shuffle results set the zero flag when the accumulator is zero.
// - Gray and shuffle results set the negative flag when the accumulator is negative.
// - Shuffle moves up to eight stack digits by accumulator order word into accumulator.
// - Each order digit gives the destination position of the matching source digit.
// - Order digit 0 or 9-F drops its source digit, contributing zero.
// - Duplicate destinations take the source digit with the most significant order digit.
// - Accumulator is 32 bits; conversions may use the full width.
package nfcu_pkg;

  // Operation select
  typedef enum logic [1:0]
  {
    OP_HEX_TO_ASCII = 2'h0,
    OP_SEGMENT_ENCODE = 2'h1,
    OP_GRAY = 2'h2,
    OP_SHUF = 2'h3
  } nfcu_op_e;

  // Table walk states, Gray coded along the usual path
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_WR_HI = 3'h3,
    ST_WR_LO = 3'h2,
    ST_DRAIN = 3'h6
  } nfcu_state_e;

  // Values after reset
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // Address space ceiling for table range checks
  localparam logic [17:0] ADDR_LIMIT = 18'h1_0000;

  // ASCII code bases
  localparam logic [7:0] ASCII_NUM_BASE = 8'h30;
  localparam logic [7:0] ASCII_ALPHA_BASE = 8'h41;
  localparam logic [7:0] ASCII_ALPHA_LAST = 8'h46;
  localparam logic [3:0] HEX_TEN = 4'ha;

  // Shuffle order digits that name a position
  localparam logic [3:0] ORDER_FIRST = 4'h1;
  localparam logic [3:0] ORDER_LAST = 4'h8;

  // Seven-segment patterns, bit 0 = segment a .. bit 6 = segment g
  localparam logic [15:0][7:0] SEGMENT_TABLE =
  {
    8'h71, 8'h79, 8'h5e, 8'h39, 8'h7c, 8'h77, 8'h6f, 8'h7f,
    8'h07, 8'h7d, 8'h6d, 8'h66, 8'h4f, 8'h5b, 8'h06, 8'h3f
  };

  // Buffer entry: address above data
  localparam int WORD_W = 16;
  localparam int ENTRY_W = 32;

endpackage

// *** pkg/nfcu_wr_if.sv ***
// Write request channel between the table walker and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface nfcu_wr_if;
  logic valid;
  logic ready;
  logic [15:0] addr;
  logic [15:0] data;

  // Producer side
  modport src (output valid, output addr, output data, input ready);
  // Buffer side
  modport snk (input valid, input addr, input data, output ready);
endinterface
`default_nettype wire

// *** rtl/nfcu_buf.sv ***
// Two-entry write buffer between the table walker and word memory
`timescale 1ns/1ps
`default_nettype none
module nfcu_buf
  import nfcu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  nfcu_wr_if.snk push,
  output logic out_valid_o,
  output logic [31:0] out_word_o,
  input wire logic out_ready_i,
  output logic empty_o
);
  logic [31:0] mem_reg [2];
  logic [31:0] mem_next [2];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic valid_reg;
  logic valid_next;
  logic pop;
  logic take;
  logic [1:0] widx;

  // Accept while an entry is free
  assign push.ready = (cnt_reg != 2'h2);
  assign pop = valid_reg && out_ready_i;
  assign take = push.valid && push.ready;

  // Shift on pop, write behind the last held entry
  always_comb
  begin
    mem_next = mem_reg;
    if (pop)
    begin
      mem_next[0] = mem_reg[1];
    end
    widx = cnt_reg - {1'b0, pop};
    if (take)
    begin
      mem_next[widx[0]] = {push.addr, push.data};
    end
    cnt_next = cnt_reg - {1'b0, pop} + {1'b0, take};
    valid_next = (cnt_next != 2'h0);
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mem_reg[0] <= 32'h0;
      mem_reg[1] <= 32'h0;
      cnt_reg <= 2'h0;
      valid_reg <= 1'b0;
    end
    else
    begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
    end
  end

  assign out_valid_o = valid_reg;
  assign out_word_o = mem_reg[0];
  assign empty_o = !valid_reg;

  // Stalled word holds until taken
  a_buf_hold_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_word_o))
    else $error("buffer output changed while stalled");

  // Full buffer refuses input
  a_buf_full_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_reg == 2'h2) |-> !push.ready)
    else $error("buffer accepts while full");
endmodule
`default_nettype wire

// *** rtl/nfcu_top.sv ***
// Number-format conversion unit: hex-to-ASCII table walk and accumulator conversions
`timescale 1ns/1ps
`default_nettype none
module nfcu_top
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i,
  input wire nfcu_pkg::nfcu_op_e op_code_i,
  input wire logic [31:0] acc_i,
  input wire logic [31:0] stack_i,
  input wire logic [15:0] operand_i,
  output logic op_ready_o,
  output logic done_o,
  output logic [31:0] acc_o,
  output logic zero_o,
  output logic neg_o,
  output logic range_o,
  output logic rd_req_o,
  output logic [15:0] rd_addr_o,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i,
  output logic wr_valid_o,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  input wire logic wr_ready_i
);
  import nfcu_pkg::*;

  // Hex digit to ASCII byte
  function automatic logic [7:0] hex_ascii(input logic [3:0] d);
    hex_ascii = (d < HEX_TEN) ? ASCII_NUM_BASE + {4'h0, d}
                              : ASCII_ALPHA_BASE + {4'h0, d - HEX_TEN};
  endfunction

  // Legal ASCII byte check
  function automatic logic is_ascii(input logic [7:0] b);
    is_ascii = (b >= ASCII_NUM_BASE && b <= ASCII_NUM_BASE + 8'h09) ||
               (b >= ASCII_ALPHA_BASE && b <= ASCII_ALPHA_LAST);
  endfunction

  // Four digits to four pattern bytes
  function automatic logic [31:0] segment_encode(input logic [15:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      r[8*i +: 8] = SEGMENT_TABLE[v[4*i +: 4]];
    end
    segment_encode = r;
  endfunction

  // Gray decode then binary to BCD of the 10-bit count
  function automatic logic [15:0] gray_bcd(input logic [15:0] g);
    logic [15:0] b;
    logic [15:0] bcd;
    b = 16'h0;
    bcd = 16'h0;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    for (int i = 9; i >= 0; i--)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (bcd[4*k +: 4] > 4'h4)
        begin
          bcd[4*k +: 4] = bcd[4*k +: 4] + 4'h3;
        end
      end
      bcd = {bcd[14:0], b[i]};
    end
    gray_bcd = bcd;
  endfunction

  // Digit shuffle under an order word
  function automatic logic [31:0] shuffle(input logic [31:0] src, input logic [31:0] ord);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (ord[4*i +: 4] >= ORDER_FIRST && ord[4*i +: 4] <= ORDER_LAST)
      begin
        // Later, more significant order digits overwrite earlier ones
        r[4*(ord[4*i +: 4] - ORDER_FIRST) +: 4] = src[4*i +: 4];
      end
    end
    shuffle = r;
  endfunction

  nfcu_state_e state_reg, state_next;
  logic [31:0] acc_reg, acc_next;
  logic zero_reg, zero_next;
  logic neg_reg, neg_next;
  logic range_reg, range_next;
  logic done_reg, done_next;
  logic ready_reg, ready_next;
  logic rd_req_reg, rd_req_next;
  logic [15:0] rd_addr_reg, rd_addr_next;
  logic [15:0] src_reg, src_next;
  logic [15:0] dst_reg, dst_next;
  logic [15:0] left_reg, left_next;
  logic [15:0] data_reg, data_next;
  nfcu_op_e last_op_reg, last_op_next;
  logic [16:0] wr_seen_reg, wr_seen_next;
  logic [15:0] cnt_copy_reg, cnt_copy_next;
  logic accept;
  logic range_bad;
  logic buf_empty;
  logic [31:0] buf_word;
  logic [17:0] src_end;
  logic [17:0] dst_end;

  nfcu_wr_if wr_if ();

  // Table operands must stay inside accumulator and address reach
  assign src_end = {2'h0, acc_i[15:0]} + {2'h0, stack_i[15:0]};
  assign dst_end = {2'h0, operand_i} + {1'b0, stack_i[15:0], 1'b0};
  assign range_bad = (|stack_i[31:16]) || (|acc_i[31:16]) ||
                     (src_end > ADDR_LIMIT) || (dst_end > ADDR_LIMIT);
  assign accept = op_valid_i && ready_reg;

  // Push one ASCII word per write state, most significant digits first
  assign wr_if.valid = (state_reg == ST_WR_HI) || (state_reg == ST_WR_LO);
  assign wr_if.addr = (state_reg == ST_WR_LO) ? dst_reg + 16'h1 : dst_reg;
  assign wr_if.data = (state_reg == ST_WR_LO) ?
                      {hex_ascii(data_reg[7:4]), hex_ascii(data_reg[3:0])} :
                      {hex_ascii(data_reg[15:12]), hex_ascii(data_reg[11:8])};

  // Operation decode and table walk
  always_comb
  begin
    state_next = state_reg;
    acc_next = acc_reg;
    zero_next = zero_reg;
    neg_next = neg_reg;
    range_next = range_reg;
    done_next = 1'b0;
    rd_req_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    left_next = left_reg;
    data_next = data_reg;
    last_op_next = last_op_reg;
    wr_seen_next = wr_seen_reg + {16'h0, wr_if.valid && wr_if.ready};
    cnt_copy_next = cnt_copy_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (accept)
        begin
          last_op_next = op_code_i;
          unique case (op_code_i)
            OP_SEGMENT_ENCODE:
            begin
              acc_next = segment_encode(acc_i[15:0]);
              done_next = 1'b1;
            end
            OP_GRAY:
            begin
              acc_next = {16'h0, gray_bcd(acc_i[15:0])};
              zero_next = (acc_next == 32'h0);
              neg_next = acc_next[31];
              done_next = 1'b1;
            end
            OP_SHUF:
            begin
              acc_next = shuffle(stack_i, acc_i);
              zero_next = (acc_next == 32'h0);
              neg_next = acc_next[31];
              done_next = 1'b1;
            end
            OP_HEX_TO_ASCII:
            begin
              acc_next = acc_i;
              range_next = range_bad;
              wr_seen_next = 17'h0;
              cnt_copy_next = stack_i[15:0];
              src_next = acc_i[15:0];
              dst_next = operand_i;
              left_next = stack_i[15:0];
              if (range_bad || stack_i[15:0] == 16'h0)
              begin
                done_next = 1'b1;
              end
              else
              begin
                rd_req_next = 1'b1;
                rd_addr_next = acc_i[15:0];
                state_next = ST_WAIT;
              end
            end
          endcase
        end
      end
      ST_WAIT:
      begin
        if (rd_valid_i)
        begin
          data_next = rd_data_i;
          state_next = ST_WR_HI;
        end
      end
      ST_WR_HI:
      begin
        if (wr_if.ready)
        begin
          state_next = ST_WR_LO;
        end
      end
      ST_WR_LO:
      begin
        if (wr_if.ready)
        begin
          left_next = left_reg - 16'h1;
          dst_next = dst_reg + 16'h2;
          if (left_reg == 16'h1)
          begin
            state_next = ST_DRAIN;
          end
          else
          begin
            src_next = src_reg + 16'h1;
            rd_req_next = 1'b1;
            rd_addr_next = src_reg + 16'h1;
            state_next = ST_WAIT;
          end
        end
      end
      ST_DRAIN:
      begin
        if (buf_empty)
        begin
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    ready_next = (state_next == ST_IDLE);
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      acc_reg <= ACC_RST;
      zero_reg <= 1'b0;
      neg_reg <= 1'b0;
      range_reg <= 1'b0;
      done_reg <= 1'b0;
      ready_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      rd_addr_reg <= PTR_RST;
      src_reg <= PTR_RST;
      dst_reg <= PTR_RST;
      left_reg <= PTR_RST;
      data_reg <= PTR_RST;
      last_op_reg <= OP_HEX_TO_ASCII;
      wr_seen_reg <= 17'h0;
      cnt_copy_reg <= PTR_RST;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      zero_reg <= zero_next;
      neg_reg <= neg_next;
      range_reg <= range_next;
      done_reg <= done_next;
      ready_reg <= ready_next;
      rd_req_reg <= rd_req_next;
      rd_addr_reg <= rd_addr_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      left_reg <= left_next;
      data_reg <= data_next;
      last_op_reg <= last_op_next;
      wr_seen_reg <= wr_seen_next;
      cnt_copy_reg <= cnt_copy_next;
    end
  end

  // Write buffer absorbs memory stalls
  nfcu_buf u_buf
  (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .push (wr_if.snk),
    .out_valid_o (wr_valid_o),
    .out_word_o (buf_word),
    .out_ready_i (wr_ready_i),
    .empty_o (buf_empty)
  );

  // Outputs
  assign op_ready_o = ready_reg;
  assign done_o = done_reg;
  assign acc_o = acc_reg;
  assign zero_o = zero_reg;
  assign neg_o = neg_reg;
  assign range_o = range_reg;
  assign rd_req_o = rd_req_reg;
  assign rd_addr_o = rd_addr_reg;
  assign wr_addr_o = buf_word[31:16];
  assign wr_data_o = buf_word[15:0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_take(nfcu_op_e op);
    op_valid_i && op_ready_o && (op_code_i == op);
  endsequence

  sequence s_flag_done;
    done_o && (last_op_reg == OP_GRAY || last_op_reg == OP_SHUF);
  endsequence

  a_segment_result: assert property (s_take(OP_SEGMENT_ENCODE) |=> done_o &&
    acc_o == segment_encode($past(acc_i[15:0])))
    else $error("segment result wrong");

  a_gray_result: assert property (s_take(OP_GRAY) |=> done_o &&
    acc_o[31:16] == 16'h0 && acc_o[15:0] == gray_bcd($past(acc_i[15:0])))
    else $error("gray result wrong");

  a_shuf_result: assert property (s_take(OP_SHUF) |=> done_o &&
    acc_o == shuffle($past(stack_i), $past(acc_i)))
    else $error("shuffle result wrong");

  a_zero_flag: assert property (s_flag_done |-> zero_o == (acc_o == 32'h0))
    else $error("zero flag wrong");

  a_neg_flag: assert property (s_flag_done |-> neg_o == acc_o[31])
    else $error("negative flag wrong");

  a_range_error: assert property (s_take(OP_HEX_TO_ASCII) ##0 range_bad |=>
    range_o && done_o && !rd_req_o)
    else $error("range error not reported");

  a_table_start: assert property (s_take(OP_HEX_TO_ASCII) ##0
    (!range_bad && stack_i[15:0] != 16'h0)
    |=> rd_req_o && !op_ready_o && rd_addr_o == $past(acc_i[15:0]))
    else $error("table walk did not start");

  a_ascii_bytes: assert property (wr_valid_o |->
    is_ascii(wr_data_o[15:8]) && is_ascii(wr_data_o[7:0]))
    else $error("non-ascii byte written");

  a_word_double: assert property (done_o && last_op_reg == OP_HEX_TO_ASCII && !range_o |->
    wr_seen_reg == {cnt_copy_reg, 1'b0})
    else $error("destination word count not doubled");
endmodule
`default_nettype wire

// *** dv/nfcu_mem_model.sv ***
// Word memory model answering the unit's read and write ports
`timescale 1ns/1ps
`default_nettype none
module nfcu_mem_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] lat_i,
  input wire logic stall_i,
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic wr_ready_o
);
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [15:0] addr = 16'h0;
  logic [1:0] cyc = 2'h0;

  initial
  begin
    rd_valid_o = 1'b0;
    rd_data_o = 16'h0;
    wr_ready_o = 1'b1;
  end

  // One answer per request after lat_i cycles; data line toggles when idle
  always @(negedge clk_i)
  begin
    cyc <= cyc + 2'h1;
    wr_ready_o <= !stall_i || cyc[1]; // Stall half the time on request
    if (rst_n_i && rd_req_i)
    begin
      busy = 1'b1;
      cnt = lat_i;
      addr = rd_addr_i;
    end
    if (busy && cnt == 4'h0)
    begin
      rd_valid_o <= 1'b1;
      rd_data_o <= {addr[7:0] ^ 8'hc5, addr[7:0]};
      busy = 1'b0;
    end
    else
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= ~rd_data_o; // No stale word after the strobe
      if (busy)
        cnt = cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** dv/number_format_conversion_unit_test.sv ***
// Self-checking bench for the number-format conversion unit
`timescale 1ns/1ps
`default_nettype none
module number_format_conversion_unit_test;
  import nfcu_pkg::*;
  localparam logic [7:0] PAT [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid = 1'b0;
  nfcu_op_e op_code = OP_SEGMENT_ENCODE;
  logic [31:0] acc = 32'h0;
  logic [31:0] stk = 32'h0;
  logic [15:0] opnd = 16'h0;
  logic [3:0] lat = 4'h0;
  logic stall = 1'b0;
  logic op_ready, done, zero, neg, range_f, rd_req, rd_valid, wr_valid, wr_ready;
  logic [31:0] acc_o;
  logic [15:0] rd_addr, rd_data, wr_addr, wr_data;
  logic [31:0] wq [$];
  int fail_count = 0;
  int check_count = 0;

  always #12.5 clk_i = ~clk_i;

  nfcu_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid), .op_code_i(op_code),
    .acc_i(acc), .stack_i(stk), .operand_i(opnd), .op_ready_o(op_ready), .done_o(done),
    .acc_o(acc_o), .zero_o(zero), .neg_o(neg), .range_o(range_f), .rd_req_o(rd_req),
    .rd_addr_o(rd_addr), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .wr_valid_o(wr_valid),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_ready_i(wr_ready));

  nfcu_mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .lat_i(lat), .stall_i(stall),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
    .wr_ready_o(wr_ready));

  // Log every accepted write as {address, data}
  always @(posedge clk_i)
    if (wr_valid && wr_ready)
      wq.push_back({wr_addr, wr_data});

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [7:0] asc(input logic [3:0] h);
    return (h < 4'ha) ? 8'h30 + h : 8'h37 + h;
  endfunction

  function automatic logic [31:0] gray_exp(input logic [15:0] g);
    logic [15:0] b;
    int v;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    v = b[9:0];
    return {16'h0, 4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction

  function automatic logic [31:0] shuf_exp(input logic [31:0] s, input logic [31:0] o);
    logic [31:0] r;
    int p;
    r = 32'h0;
    for (int i = 0; i < 8; i++)
    begin
      p = o[4 * i +: 4];
      if (p >= 1 && p <= 8)
        r[4 * (p - 1) +: 4] = s[4 * i +: 4];
    end
    return r;
  endfunction

  // Issue one operation and expect done within lim cycles of acceptance
  task automatic do_op(input nfcu_op_e c, input logic [31:0] a, input logic [31:0] s,
    input logic [15:0] d, input int lim);
    int n;
    @(negedge clk_i);
    op_valid = 1'b1;
    op_code = c;
    acc = a;
    stk = s;
    opnd = d;
    n = 0;
    // Ready is judged at the falling edge, so the next rising edge takes
    while (op_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    op_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    check("done", done, 1'b1);
  endtask

  // All sixteen digit patterns, upper accumulator half ignored
  task automatic t_segment;
    logic [15:0] v;
    for (int k = 0; k < 4; k++)
    begin
      v = {4'(4 * k + 3), 4'(4 * k + 2), 4'(4 * k + 1), 4'(4 * k)};
      do_op(OP_SEGMENT_ENCODE, {16'h5a5a, v}, 32'h0, 16'h0, 0);
      check("segment", acc_o, {PAT[v[15:12]], PAT[v[11:8]], PAT[v[7:4]], PAT[v[3:0]]});
    end
  endtask

  // Gray decode across 512 and 1024 count ranges, zero and full-width inputs
  task automatic t_gray;
    int ns [7] = '{0, 1, 9, 359, 511, 1023, 40000};
    int ps [4] = '{0, 359, 0, 719};
    int offs [4] = '{76, 76, 152, 152};
    int v;
    logic [15:0] g;
    foreach (ns[k])
    begin
      g = 16'(ns[k] ^ (ns[k] >> 1));
      do_op(OP_GRAY, {16'h0, g}, 32'h0, 16'h0, 0);
      check("gray", acc_o, gray_exp(g));
      check("gray zero", zero, ns[k] == 0);
      check("gray neg", neg, 1'b0);
    end
    // Centred 360 and 720 count encoders, caller removes the offset
    foreach (ps[k])
    begin
      v = ps[k] + offs[k];
      g = 16'(v ^ (v >> 1));
      do_op(OP_GRAY, {16'h0, g}, 32'h0, 16'h0, 0);
      v = acc_o[15:12] * 1000 + acc_o[11:8] * 100 + acc_o[7:4] * 10 + acc_o[3:0];
      check("gray offset", v - offs[k], ps[k]);
    end
  endtask

  // Identity, reversal, dropped digits, duplicates, all-zero result
  task automatic t_shuf;
    logic [31:0] ss [5] = '{32'h12345678, 32'h12345678, 32'h12345678, 32'h9abcdef1, 32'h0};
    logic [31:0] os [5] = '{32'h87654321, 32'h12345678, 32'h0f9a4321, 32'h11111111, 32'h8};
    logic [31:0] e;
    foreach (ss[k])
    begin
      e = shuf_exp(ss[k], os[k]);
      do_op(OP_SHUF, os[k], ss[k], 16'h0, 0);
      check("shuf", acc_o, e);
      check("shuf zero", zero, e == 32'h0);
      check("shuf neg", neg, e[31]);
    end
    do_op(OP_SEGMENT_ENCODE, 32'h0, 32'h0, 16'h0, 0);
    check("flag hold", {neg, zero}, 2'h1);
  endtask

  // Table walk with expected write stream
  task automatic table_ok(input logic [15:0] src, input logic [15:0] cnt, input logic [15:0] dst);
    logic [15:0] w;
    do_op(OP_HEX_TO_ASCII, {16'h0, src}, {16'h0, cnt}, dst, 400);
    check("table range", range_f, 1'b0);
    check("table acc", acc_o, {16'h0, src});
    check("table writes", wq.size(), 2 * cnt);
    for (int k = 0; k < cnt; k++)
    begin
      w = src + 16'(k);
      w = {w[7:0] ^ 8'hc5, w[7:0]};
      check("wr hi", wq.pop_front(), {dst + 16'(2 * k), asc(w[15:12]), asc(w[11:8])});
      check("wr lo", wq.pop_front(), {dst + 16'(2 * k + 1), asc(w[7:4]), asc(w[3:0])});
    end
  endtask

  task automatic t_table_walk;
    lat = 4'h2;
    stall = 1'b1;
    table_ok(16'h0010, 16'h3, 16'h0040);
    lat = 4'h0;
    stall = 1'b0;
    table_ok(16'hffff, 16'h1, 16'hfffe);
  endtask

  // Operands out of reach refused with no memory traffic
  task automatic t_table_range;
    logic [31:0] as [4] = '{32'h0001_0000, 32'h0000_ffff, 32'h0, 32'h0};
    logic [31:0] ks [4] = '{32'h1, 32'h2, 32'h1, 32'h0001_0001};
    logic [15:0] ds [4] = '{16'h0, 16'h0, 16'hffff, 16'h0};
    foreach (as[k])
    begin
      do_op(OP_HEX_TO_ASCII, as[k], ks[k], ds[k], 0);
      check("range set", range_f, 1'b1);
      check("range traffic", wq.size(), 0);
    end
    do_op(OP_HEX_TO_ASCII, 32'h20, 32'h0, 16'h30, 0);
    check("range clear", range_f, 1'b0);
    check("count zero", wq.size(), 0);
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #1000000;
    fail_count++;
    finish_test;
  end

  initial
  begin
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check("reset acc", acc_o, 32'h0);
    t_segment;
    t_gray;
    t_shuf;
    t_table_walk;
    t_table_range;
    finish_test;
  end
endmodule
`default_nettype wire
